// ===== slnac_pkg.sv
package slnac_pkg;

  // clock and timing
  localparam int CLK_HZ            = 100_000_000;
  localparam int CLK_PERIOD_NS     = 1_000_000_000 / CLK_HZ;
  localparam int LOCK_TIMEOUT_MS   = 1000;
  localparam int LOCK_TIMEOUT_CLKS = (CLK_HZ / 1000) * LOCK_TIMEOUT_MS;

  // communication cycle: {extension, setting} counts cycle units of 1 us
  localparam int CYCLE_UNIT_NS     = 1000;
  localparam int CYCLE_UNIT_CLKS   = CYCLE_UNIT_NS / CLK_PERIOD_NS;
  localparam int FAST_CYCLE_US     = 250;
  localparam int FAST_CYCLE_UNITS  = (FAST_CYCLE_US * 1000) / CYCLE_UNIT_NS;
  localparam int PER_W             = 24;
  localparam int CFG_W             = 8;
  localparam int EXT_FUNC_W        = 16;
  localparam int SYNC_MODE_BIT     = 1;
  // period tolerance of 1/2048, just inside the 0.05 percent band
  localparam int TOL_SHIFT         = 11;
  localparam int LOCK_FRAMES       = 8;
  localparam int LOCK_CNT_W        = 4;

  // link fields
  localparam int UCNT_W            = 8;
  localparam int CODE_W            = 8;

  // node address switch
  localparam int ADDR_SW_W         = 8;
  localparam int NODE_W            = 5;
  localparam logic [ADDR_SW_W-1:0] ADDR_MAX = 8'h1f;

  // protective error codes, binary value of the decimal code
  localparam logic [CODE_W-1:0] ERR_PLL_MAIN  = 8'h50;
  localparam logic [CODE_W-1:0] ERR_PLL_SUB   = 8'h03;
  localparam logic [CODE_W-1:0] ERR_ADDR_MAIN = 8'h52;
  localparam logic [CODE_W-1:0] ERR_ADDR_SUB  = 8'h00;

  // controller register map over apb
  localparam int APB_AW = 8;
  localparam logic [APB_AW-1:0] OFS_CTRL     = 8'h00;
  localparam logic [APB_AW-1:0] OFS_CMD      = 8'h04;
  localparam logic [APB_AW-1:0] OFS_PERIOD   = 8'h08;
  localparam logic [APB_AW-1:0] OFS_STATUS   = 8'h0c;
  localparam logic [APB_AW-1:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [APB_AW-1:0] OFS_IRQ_MASK = 8'h14;

  localparam int CTRL_RUN_BIT    = 0;
  localparam int CTRL_MODE_BIT   = 1;
  localparam int CMD_CLEAR_BIT   = 0;
  localparam int CMD_SOFT_BIT    = 1;
  localparam int ST_LOCK_BIT     = 0;
  localparam int ST_ERR_BIT      = 1;
  localparam int ST_MAIN_LSB     = 8;
  localparam int ST_SUB_LSB      = 16;
  localparam int IRQ_LOCK_BIT    = 0;
  localparam int IRQ_ERR_BIT     = 1;
  localparam int IRQ_W           = 2;

  localparam logic [PER_W-1:0] PERIOD_RST = 24'h0186a0;

  // synchronisation supervisor states, gray along idle-sync-lock-err
  typedef enum logic [1:0] {
    SLNAC_IDLE = 2'b00,
    SLNAC_SYNC = 2'b01,
    SLNAC_LOCK = 2'b11,
    SLNAC_ERR  = 2'b10
  } slnac_state_t;

endpackage

// ===== slnac_link_if.sv
`timescale 1ns/10ps
interface slnac_link_if;
  import slnac_pkg::*;

  logic              frame;
  logic [UCNT_W-1:0] ucnt;
  logic              sync_mode;
  logic              alarm_clear;
  logic              soft_reset;
  logic              locked;
  logic              err_act;
  logic [CODE_W-1:0] err_main;
  logic [CODE_W-1:0] err_sub;

  modport dev (
    input  frame,
    input  ucnt,
    input  sync_mode,
    input  alarm_clear,
    input  soft_reset,
    output locked,
    output err_act,
    output err_main,
    output err_sub
  );

  modport host (
    output frame,
    output ucnt,
    output sync_mode,
    output alarm_clear,
    output soft_reset,
    input  locked,
    input  err_act,
    input  err_main,
    input  err_sub
  );
endinterface

// ===== slnac_host.sv
`timescale 1ns/10ps
module slnac_host
  import slnac_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq,
  slnac_link_if.host             link
);

  logic              run_q;
  logic              mode_q;
  logic [PER_W-1:0]  period_q;
  logic [IRQ_W-1:0]  ist_q;
  logic [IRQ_W-1:0]  imask_q;
  logic [PER_W-1:0]  tick_q;
  logic              frame_q;
  logic [UCNT_W-1:0] ucnt_q;
  logic              clr_q;
  logic              soft_q;
  logic              lock_prev_q;
  logic              err_prev_q;
  logic [31:0]       rdata_d;
  logic              mapped_d;
  logic              acc;
  logic              wr;
  logic [IRQ_W-1:0]  ev;

  // access phase, answered with one wait state; a write lands on the completing edge
  assign acc = psel & penable & ~pready;
  assign wr  = psel & penable & pready & pwrite;

  // read mux and decode
  always_comb begin
    rdata_d  = 32'h0000_0000;
    mapped_d = 1'b1;
    case (paddr)
      OFS_CTRL: begin
        rdata_d[CTRL_RUN_BIT]  = run_q;
        rdata_d[CTRL_MODE_BIT] = mode_q;
      end
      OFS_CMD: rdata_d = 32'h0000_0000;
      OFS_PERIOD: rdata_d[PER_W-1:0] = period_q;
      OFS_STATUS: begin
        rdata_d[ST_LOCK_BIT]                 = link.locked;
        rdata_d[ST_ERR_BIT]                  = link.err_act;
        rdata_d[ST_MAIN_LSB +: CODE_W]       = link.err_main;
        rdata_d[ST_SUB_LSB +: CODE_W]        = link.err_sub;
      end
      OFS_IRQ_STAT: rdata_d[IRQ_W-1:0] = ist_q;
      OFS_IRQ_MASK: rdata_d[IRQ_W-1:0] = imask_q;
      default: mapped_d = 1'b0;
    endcase
  end

  // apb answer
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= acc;
      pslverr <= acc & ~mapped_d;
      if (acc && !pwrite) begin
        prdata <= rdata_d;
      end
    end
  end

  // control registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      run_q    <= 1'b0;
      mode_q   <= 1'b0;
      period_q <= PERIOD_RST;
      imask_q  <= '0;
    end else if (ce && wr) begin
      if (paddr == OFS_CTRL) begin
        run_q  <= pwdata[CTRL_RUN_BIT];
        mode_q <= pwdata[CTRL_MODE_BIT];
      end
      if (paddr == OFS_PERIOD) begin
        period_q <= pwdata[PER_W-1:0];
      end
      if (paddr == OFS_IRQ_MASK) begin
        imask_q <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // one-cycle command pulses toward the drive
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      clr_q  <= 1'b0;
      soft_q <= 1'b0;
    end else if (ce) begin
      clr_q  <= wr && (paddr == OFS_CMD) && pwdata[CMD_CLEAR_BIT];
      soft_q <= wr && (paddr == OFS_CMD) && pwdata[CMD_SOFT_BIT];
    end
  end

  // frame generator: exact period, counter advances every frame
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tick_q  <= '0;
      frame_q <= 1'b0;
      ucnt_q  <= '0;
    end else if (ce) begin
      frame_q <= 1'b0;
      if (!run_q) begin
        tick_q <= '0;
      end else if (tick_q + 24'h000001 >= period_q) begin
        tick_q  <= '0;
        frame_q <= 1'b1;
        ucnt_q  <= ucnt_q + 8'h01;
      end else begin
        tick_q <= tick_q + 24'h000001;
      end
    end
  end

  // sticky events, set wins over write-one-to-clear
  assign ev[IRQ_LOCK_BIT] = link.locked & ~lock_prev_q;
  assign ev[IRQ_ERR_BIT]  = link.err_act & ~err_prev_q;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lock_prev_q <= 1'b0;
      err_prev_q  <= 1'b0;
      ist_q       <= '0;
      irq         <= 1'b0;
    end else if (ce) begin
      lock_prev_q <= link.locked;
      err_prev_q  <= link.err_act;
      if (wr && paddr == OFS_IRQ_STAT) begin
        ist_q <= (ist_q & ~pwdata[IRQ_W-1:0]) | ev;
      end else begin
        ist_q <= ist_q | ev;
      end
      irq <= |(ist_q & imask_q);
    end
  end

  // link drive
  assign link.frame       = frame_q;
  assign link.ucnt        = ucnt_q;
  assign link.sync_mode   = mode_q;
  assign link.alarm_clear = clr_q;
  assign link.soft_reset  = soft_q;

endmodule

// ===== slnac_dev.sv
// What this block does
// - raise error 80.3 if unlocked after 1 s
// - node address above 31 raises error 82.0
// - host frame period within 0.05 percent
// - fast cycles need counter advance every frame
// - configured cycle must equal host cycle
// - sync mode bit must match host mode
// - address error ignores alarm clear
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/10ps
module slnac_dev
  import slnac_pkg::*;
#(
  parameter int LOCK_TIMEOUT = LOCK_TIMEOUT_CLKS
) (
  input  wire logic                  clk_sys,
  input  wire logic                  arst_n,
  input  wire logic                  ce,
  input  wire logic                  sync_req,
  input  wire logic [ADDR_SW_W-1:0]  addr_sw,
  input  wire logic [CFG_W-1:0]      comm_cycle_setting,
  input  wire logic [CFG_W-1:0]      comm_cycle_extension_setting,
  input  wire logic [EXT_FUNC_W-1:0] extended_function_setup_one,
  output logic      [NODE_W-1:0]     node_addr,
  output logic                       addr_taken,
  output logic                       locked,
  output logic                       err_act,
  output logic      [CODE_W-1:0]     err_main,
  output logic      [CODE_W-1:0]     err_sub,
  slnac_link_if.dev                  link
);

  slnac_state_t             state_q;
  slnac_state_t             state_d;
  logic [ADDR_SW_W-1:0]     sw_meta_q;
  logic [ADDR_SW_W-1:0]     sw_sync_q;
  logic [1:0]               boot_q;
  logic                     take;
  logic [PER_W-1:0]         period;
  logic [PER_W-1:0]         tol;
  logic [2*CFG_W-1:0]       cycle_units;
  logic                     fast_cycle;
  logic [PER_W-1:0]         ivl_q;
  logic                     have_prev_q;
  logic [UCNT_W-1:0]        ucnt_prev_q;
  logic [PER_W-1:0]         dev_abs;
  logic                     good_frame;
  logic [LOCK_CNT_W-1:0]    good_q;
  logic [31:0]              timer_q;
  logic                     timeout;
  logic                     set_pll;
  logic                     set_addr;
  logic                     fixed_q;
  logic                     may_clear;

  // node address switch passes two flip-flops
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sw_meta_q <= '0;
      sw_sync_q <= '0;
    end else if (ce) begin
      sw_meta_q <= addr_sw;
      sw_sync_q <= sw_meta_q;
    end
  end

  // capture once, after the synchroniser has filled
  assign take = (boot_q == 2'h2) && !addr_taken;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      boot_q     <= 2'h0;
      addr_taken <= 1'b0;
      node_addr  <= '0;
    end else if (ce) begin
      if (boot_q != 2'h2) begin
        boot_q <= boot_q + 2'h1;
      end
      if (take) begin
        addr_taken <= 1'b1;
        node_addr  <= sw_sync_q[NODE_W-1:0];
      end
    end
  end

  assign set_addr = take && (sw_sync_q > ADDR_MAX);

  // expected frame period from the cycle settings
  assign cycle_units = {comm_cycle_extension_setting, comm_cycle_setting};
  assign period      = PER_W'(cycle_units) * PER_W'(CYCLE_UNIT_CLKS);
  assign tol         = period >> TOL_SHIFT;
  assign fast_cycle  = cycle_units <= (2*CFG_W)'(FAST_CYCLE_UNITS);

  // frame interval measurement, saturating
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ivl_q       <= '0;
      have_prev_q <= 1'b0;
      ucnt_prev_q <= '0;
    end else if (ce) begin
      if (state_q != SLNAC_SYNC) begin
        ivl_q       <= '0;
        have_prev_q <= 1'b0;
      end else if (link.frame) begin
        ivl_q       <= 24'h000001;
        have_prev_q <= 1'b1;
        ucnt_prev_q <= link.ucnt;
      end else if (ivl_q != '1) begin
        ivl_q <= ivl_q + 24'h000001;
      end
    end
  end

  // a frame counts toward lock when period and mode agree, and in fast cycles the counter too
  assign dev_abs = (ivl_q > period) ? (ivl_q - period) : (period - ivl_q);

  always_comb begin
    good_frame = have_prev_q && (dev_abs <= tol);
    if (fast_cycle && (link.ucnt != ucnt_prev_q + 8'h01)) begin
      good_frame = 1'b0;
    end
    if (link.sync_mode != extended_function_setup_one[SYNC_MODE_BIT]) begin
      good_frame = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      good_q <= '0;
    end else if (ce) begin
      if (state_q != SLNAC_SYNC) begin
        good_q <= '0;
      end else if (link.frame && have_prev_q) begin
        good_q <= good_frame ? good_q + 4'h1 : 4'h0;
      end
    end
  end

  // lock supervision timer
  assign timeout = (state_q == SLNAC_SYNC) && (timer_q == 32'(LOCK_TIMEOUT - 1));

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      timer_q <= '0;
    end else if (ce) begin
      if (state_q != SLNAC_SYNC) begin
        timer_q <= '0;
      end else if (!timeout) begin
        timer_q <= timer_q + 32'h0000_0001;
      end
    end
  end

  assign set_pll = timeout && (good_q != 4'(LOCK_FRAMES));

  // supervisor state
  always_comb begin
    state_d = state_q;
    case (state_q)
      SLNAC_IDLE: begin
        if (sync_req && !err_act) begin
          state_d = SLNAC_SYNC;
        end
      end
      SLNAC_SYNC: begin
        if (set_pll) begin
          state_d = SLNAC_ERR;
        end else if (!sync_req) begin
          state_d = SLNAC_IDLE;
        end else if (good_q == 4'(LOCK_FRAMES)) begin
          state_d = SLNAC_LOCK;
        end
      end
      SLNAC_LOCK: begin
        if (!sync_req) begin
          state_d = SLNAC_IDLE;
        end
      end
      SLNAC_ERR: begin
        if (!err_act) begin
          state_d = SLNAC_IDLE;
        end
      end
      default: state_d = SLNAC_IDLE;
    endcase
    if (link.soft_reset && !set_pll) begin
      state_d = SLNAC_IDLE;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= SLNAC_IDLE;
      locked  <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      locked  <= (state_d == SLNAC_LOCK);
    end
  end

  // protective error latch; a new error wins over any clear
  assign may_clear = link.soft_reset || (link.alarm_clear && !fixed_q);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      err_act  <= 1'b0;
      fixed_q  <= 1'b0;
      err_main <= '0;
      err_sub  <= '0;
    end else if (ce) begin
      if (set_addr) begin
        err_act  <= 1'b1;
        fixed_q  <= 1'b1;
        err_main <= ERR_ADDR_MAIN;
        err_sub  <= ERR_ADDR_SUB;
      end else if (set_pll) begin
        err_act <= 1'b1;
        if (!err_act || !fixed_q) begin
          err_main <= ERR_PLL_MAIN;
          err_sub  <= ERR_PLL_SUB;
        end
      end else if (may_clear) begin
        err_act  <= 1'b0;
        fixed_q  <= 1'b0;
        err_main <= '0;
        err_sub  <= '0;
      end
    end
  end

  // report toward the controller
  assign link.locked   = locked;
  assign link.err_act  = err_act;
  assign link.err_main = err_main;
  assign link.err_sub  = err_sub;

endmodule

// ===== slnac_chk_sva.sv
`timescale 1ns/10ps
module slnac_chk_sva
  import slnac_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              arst_n,
  input wire logic              frame,
  input wire logic [UCNT_W-1:0] ucnt,
  input wire logic              alarm_clear,
  input wire logic              soft_reset,
  input wire logic              locked,
  input wire logic              err_act,
  input wire logic [CODE_W-1:0] err_main,
  input wire logic [CODE_W-1:0] err_sub
);
  logic [3:0] fcnt_q;
  logic       locked_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // frames seen since the last soft reset or loss of lock, saturating
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fcnt_q   <= 4'h0;
      locked_q <= 1'b0;
    end else begin
      locked_q <= locked;
      if (soft_reset || (locked_q && !locked)) begin
        fcnt_q <= 4'h0;
      end else if (frame && fcnt_q != 4'hf) begin
        fcnt_q <= fcnt_q + 4'h1;
      end
    end
  end

  a_code_valid: assert property (
    err_act |-> ({err_main, err_sub} == {ERR_PLL_MAIN, ERR_PLL_SUB}
      || {err_main, err_sub} == {ERR_ADDR_MAIN, ERR_ADDR_SUB}))
    else $error("error code is not a known code");
  a_code_idle: assert property (
    !err_act |-> err_main == 8'h00 && err_sub == 8'h00)
    else $error("error code shown without error");
  a_err_sticky: assert property (
    err_act && !alarm_clear && !soft_reset |=> err_act && $stable(err_main) && $stable(err_sub))
    else $error("error dropped or changed without a clear");
  a_addr_keep: assert property (
    alarm_clear && err_act && err_main == ERR_ADDR_MAIN && !soft_reset
      |=> err_act && err_main == ERR_ADDR_MAIN)
    else $error("address error left on alarm clear");
  a_pll_clear: assert property (
    alarm_clear && err_act && err_main == ERR_PLL_MAIN && !soft_reset |=> !err_act)
    else $error("lock error kept after alarm clear");
  a_soft_clear: assert property (
    soft_reset |=> !err_act && !locked)
    else $error("soft reset left error or lock");
  a_lock_frames: assert property (
    $rose(locked) |-> $past(frame, 2) && fcnt_q >= LOCK_FRAMES)
    else $error("lock gained with too few frames");
  a_ucnt_step: assert property (
    $changed(ucnt) |-> frame && ucnt == $past(ucnt) + 8'h01)
    else $error("update counter moved wrongly");
endmodule

// ===== sync_lock_and_node_address_check_bench.sv
`timescale 1ns/10ps
module sync_lock_and_node_address_check_bench;
  import slnac_pkg::*;
  localparam int LT = 4000;
  logic              clk_sys;
  logic              arst_n;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              irq;
  logic              sync_req;
  logic [7:0]        addr_sw;
  logic [NODE_W-1:0] node_addr;
  logic              addr_taken;
  logic              dev_locked;
  logic              dev_err;
  logic [CODE_W-1:0] dev_main;
  logic [CODE_W-1:0] dev_sub;
  logic [32:0]       dev_st;
  logic [CFG_W-1:0]  cyc_set;
  logic [15:0]       efs;
  logic [32:0]       exp_q[$];
  logic [7:0]        sw0;
  int                error_cnt;
  int                compares;
  int                seed;
  int                n;

  slnac_link_if link ();

  slnac_host slnac_host_i (.clk_sys(clk_sys), .arst_n(arst_n), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .link(link));

  slnac_dev #(.LOCK_TIMEOUT(LT)) slnac_dev_i (.clk_sys(clk_sys), .arst_n(arst_n), .ce(1'b1),
    .sync_req(sync_req), .addr_sw(addr_sw), .comm_cycle_setting(cyc_set),
    .comm_cycle_extension_setting(8'h00), .extended_function_setup_one(efs),
    .node_addr(node_addr), .addr_taken(addr_taken), .locked(dev_locked), .err_act(dev_err),
    .err_main(dev_main), .err_sub(dev_sub), .link(link));

  // drive-end outputs gathered for direct compares
  assign dev_st = {15'h0, dev_locked, dev_err, dev_main, dev_sub};

  slnac_chk_sva slnac_chk_sva_i (.clk_sys(clk_sys), .arst_n(arst_n), .frame(link.frame),
    .ucnt(link.ucnt), .alarm_clear(link.alarm_clear), .soft_reset(link.soft_reset),
    .locked(link.locked), .err_act(link.err_act), .err_main(link.err_main),
    .err_sub(link.err_sub));

  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;

  task automatic chk(input logic [32:0] seen, input logic [32:0] expv);
    compares++;
    if (seen !== expv) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask

  task automatic wrap_up;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= we;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic settle;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic pwr_up(input logic [7:0] sw);
    arst_n  <= 1'b0;
    addr_sw <= sw;
    repeat (8) @(posedge clk_sys);
    arst_n  <= 1'b1;
    repeat (6) @(posedge clk_sys);
  endtask

  // read answers against the oldest note
  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) chk(33'h1ffffffff, 33'h0);
      else chk({pslverr, prdata}, exp_q.pop_front());
    end
  end

  // watchdog
  initial begin
    #400000;
    error_cnt++;
    wrap_up;
  end

  // main sequence
  initial begin
    clk_sys = 1'b0;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sync_req = 1'b0;
    addr_sw = 8'h00;
    cyc_set = 8'h02;
    efs = 16'h0002;
    error_cnt = 0;
    compares = 0;
    seed = 32'hf5fbdf0b;
    sw0 = 8'($random(seed)) & ADDR_MAX;
    pwr_up(sw0);
    chk({27'h0, addr_taken, node_addr}, {27'h0, 1'b1, sw0[4:0]});
    addr_sw <= 8'($random(seed)) | 8'h80;
    rd(OFS_STATUS, 33'h0);
    rd(OFS_PERIOD, {9'h0, PERIOD_RST});
    rd(8'h18, 33'h100000000);
    wr(OFS_IRQ_MASK, 32'h3);
    wr(OFS_PERIOD, 32'd200);
    wr(OFS_CTRL, 32'h3);
    sync_req <= 1'b1;
    n = 0;
    while (link.locked !== 1'b1 && n < LT) begin
      @(posedge clk_sys);
      n++;
    end
    chk(33'(n < LT), 33'h1);
    chk(dev_st, {15'h0, 2'b10, 16'h0000});
    settle;
    chk({32'h0, irq}, 33'h1);
    rd(OFS_STATUS, 33'h1);
    rd(OFS_IRQ_STAT, 33'h1);
    wr(OFS_IRQ_STAT, 32'h1);
    rd(OFS_IRQ_STAT, 33'h0);
    chk({27'h0, addr_taken, node_addr}, {27'h0, 1'b1, sw0[4:0]});
    $display("test lock done");
    // host mode off, period one clock off, drive cycle off, drive mode off
    for (int k = 0; k < 4; k++) begin
      sync_req <= 1'b0;
      cyc_set  <= (k == 2) ? 8'h03 : 8'h02;
      efs      <= (k == 3) ? 16'h0000 : 16'h0002;
      wr(OFS_PERIOD, (k == 1) ? 32'd201 : 32'd200);
      wr(OFS_CTRL, (k == 0) ? 32'h1 : 32'h3);
      sync_req <= 1'b1;
      n = 0;
      while (link.err_act !== 1'b1 && n < LT + 50) begin
        @(posedge clk_sys);
        n++;
      end
      chk(33'(n >= LT - 2 && n <= LT + 3), 33'h1);
      chk(dev_st, {15'h0, 2'b01, ERR_PLL_MAIN, ERR_PLL_SUB});
      sync_req <= 1'b0;
      rd(OFS_STATUS, 33'h000035002);
      rd(OFS_IRQ_STAT, 33'h2);
      wr(OFS_IRQ_MASK, 32'h1);
      settle;
      chk({32'h0, irq}, 33'h0);
      wr(OFS_IRQ_MASK, 32'h3);
      settle;
      chk({32'h0, irq}, 33'h1);
      wr(OFS_CMD, 32'h1);
      rd(OFS_STATUS, 33'h0);
      wr(OFS_IRQ_STAT, 32'h2);
      settle;
      chk({32'h0, irq}, 33'h0);
      $display("test sync fault %0d done", k);
    end
    pwr_up(8'h20);
    chk(dev_st, {15'h0, 2'b01, ERR_ADDR_MAIN, ERR_ADDR_SUB});
    rd(OFS_STATUS, 33'h000005202);
    wr(OFS_CMD, 32'h1);
    rd(OFS_STATUS, 33'h000005202);
    addr_sw <= 8'h03;
    wr(OFS_CMD, 32'h2);
    rd(OFS_STATUS, 33'h0);
    settle;
    chk({27'h0, addr_taken, node_addr}, {27'h0, 1'b1, 5'h00});
    $display("test address done");
    wrap_up;
  end
endmodule
